// ==== rtl/tmh_timer_ctrl.sv ====
// tmh_timer_ctrl.sv - mode, carrier and pin assignment registers of the
// 8-bit compare timer, its counter, output control and pin mux.
// assumes bus accesses and the companion match pulse come from core-clock
// logic; the low-speed oscillator arrives asynchronously on a pin.
`timescale 1ns/1ns
`include "tmh_consts.svh"

module tmh_timer_ctrl
   import tmh_pkg::*;
(
   input wire logic CORE_CLK_IN,          // 20 MHz peripheral clock
   input wire logic RSTN_IN,              // async reset, active low
   input wire tmh_bus_s BUS_IN,           // internal bus access
   input wire logic [7:0] CMP0_VAL_IN,    // first compare value
   input wire logic [7:0] CMP1_VAL_IN,    // second compare value
   input wire logic COMPANION_IRQ_IN,     // companion timer match pulse
   input wire logic LSO_CLK_IN,           // low-speed oscillator pin
   output logic [7:0] RDATA_OUT,          // read data, held until next read
   output logic COMPARE_IRQ_OUT,          // match interrupt pulse
   output logic TIMER_OUT,                // timer output before pin mux
   output logic [1:0] MODE_OUT,           // operating mode, for datapath
   output tmh_pin_s P3B0_PIN_OUT,         // default pin
   output tmh_pin_s P3B4_PIN_OUT,         // port 3 bit 4 pin
   output tmh_pin_s P0B0_PIN_OUT          // port 0 bit 0 pin
);

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   logic [7:0] mode_q, mode_d, car_q, car_d, pin_q, pin_d;
   logic [7:0] p0_dir_q, p0_dir_d, p3_dir_q, p3_dir_d;
   logic [7:0] p0_lat_q, p0_lat_d, p3_lat_q, p3_lat_d;
   logic [7:0] rdata_d;
   logic nrz_q, nrz_d;

   // new register value after a byte write or a single-bit operation
   function automatic logic [7:0] bus_merge(input logic [7:0] old, input tmh_bus_s b,
                                            input logic [15:0] ofs, input logic [7:0] wm);
      logic [7:0] v;
      v = old;
      if (b.addr == ofs) begin
         if (b.wr) begin
            v = b.wdata;
         end else if (b.bit_set) begin
            v = old | (8'h01 << b.bit_sel);
         end else if (b.bit_clr) begin
            v = old & ~(8'h01 << b.bit_sel);
         end
      end
      return (v & wm) | (old & ~wm);
   endfunction

   always_comb begin
      mode_d = bus_merge(mode_q, BUS_IN, `TMH_OFS_MODE, 8'hff);
      car_d = bus_merge(car_q, BUS_IN, `TMH_OFS_CARRIER, `TMH_CAR_WMASK);
      pin_d = bus_merge(pin_q, BUS_IN, `TMH_OFS_PIN_ASSIGN, `TMH_PIN_WMASK);
      p0_dir_d = bus_merge(p0_dir_q, BUS_IN, `TMH_OFS_P0_DIR, `TMH_P0_DIR_WMASK);
      p3_dir_d = bus_merge(p3_dir_q, BUS_IN, `TMH_OFS_P3_DIR, 8'hff);
      p0_lat_d = bus_merge(p0_lat_q, BUS_IN, `TMH_OFS_P0_LATCH, 8'hff);
      p3_lat_d = bus_merge(p3_lat_q, BUS_IN, `TMH_OFS_P3_LATCH, 8'hff);
      rdata_d = RDATA_OUT;
      if (BUS_IN.rd) begin
         case (BUS_IN.addr)
            `TMH_OFS_MODE: rdata_d = mode_q;
            `TMH_OFS_CARRIER: rdata_d = {car_q[7:1], nrz_q};
            `TMH_OFS_PIN_ASSIGN: rdata_d = pin_q;
            `TMH_OFS_P0_DIR: rdata_d = p0_dir_q;
            `TMH_OFS_P3_DIR: rdata_d = p3_dir_q;
            `TMH_OFS_P0_LATCH: rdata_d = p0_lat_q;
            `TMH_OFS_P3_LATCH: rdata_d = p3_lat_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         mode_q <= `TMH_RST_ZERO;
         car_q <= `TMH_RST_ZERO;
         pin_q <= `TMH_RST_ZERO;
         p0_dir_q <= `TMH_RST_DIR;
         p3_dir_q <= `TMH_RST_DIR;
         p0_lat_q <= `TMH_RST_ZERO;
         p3_lat_q <= `TMH_RST_ZERO;
         RDATA_OUT <= 8'h00;
      end else begin
         mode_q <= mode_d;
         car_q <= car_d;
         pin_q <= pin_d;
         p0_dir_q <= p0_dir_d;
         p3_dir_q <= p3_dir_d;
         p0_lat_q <= p0_lat_d;
         p3_lat_q <= p3_lat_d;
         RDATA_OUT <= rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // low-speed oscillator synchroniser and edge
   // ----------------------------------------------------------------------
   logic lso_s1_q, lso_s2_q, lso_prev_q, comp_prev_q;
   logic lso_tick, tick, comp_rise;

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         lso_s1_q <= 1'b0;
         lso_s2_q <= 1'b0;
         lso_prev_q <= 1'b0;
         comp_prev_q <= 1'b0;
      end else begin
         lso_s1_q <= LSO_CLK_IN;
         lso_s2_q <= lso_s1_q;
         lso_prev_q <= lso_s2_q;
         comp_prev_q <= COMPANION_IRQ_IN;
      end
   end

   assign lso_tick = lso_s2_q && !lso_prev_q;
   assign comp_rise = COMPANION_IRQ_IN && !comp_prev_q;

   tmh_prescale #(
      .PRS_W(12),
      .LSO_W(15)
   ) u_prescale (
      .clk_in(CORE_CLK_IN),
      .rstn_in(RSTN_IN),
      .run_in(mode_q[`TMH_MODE_EN_BIT]),
      .cks_in(mode_q[`TMH_MODE_CKS_HI:`TMH_MODE_CKS_LO]),
      .lso_tick_in(lso_tick),
      .tick_out(tick)
   );

   // ----------------------------------------------------------------------
   // counter, compare sequencing and output level
   // ----------------------------------------------------------------------
   logic [7:0] cnt_q, cnt_d;
   logic phase_q, phase_d, wave_q, wave_d, carrier_q, carrier_d;
   logic irq_d, tout_d, level, en, tolev, toen, rmc, nrzb;
   logic match0, match1;
   tmh_mode_e mode;

   assign en = mode_q[`TMH_MODE_EN_BIT];
   assign tolev = mode_q[`TMH_MODE_TOLEV_BIT];
   assign toen = mode_q[`TMH_MODE_TOEN_BIT];
   assign rmc = car_q[`TMH_CAR_RMC_BIT];
   assign nrzb = car_q[`TMH_CAR_NRZB_BIT];
   assign mode = tmh_mode_e'(mode_q[`TMH_MODE_MD_HI:`TMH_MODE_MD_LO]);
   assign match0 = cnt_q == CMP0_VAL_IN;
   assign match1 = cnt_q == CMP1_VAL_IN;

   always_comb begin
      cnt_d = cnt_q;
      phase_d = phase_q;
      wave_d = wave_q;
      carrier_d = carrier_q;
      irq_d = 1'b0;
      if (!en) begin
         cnt_d = 8'h00;
         phase_d = 1'b0;
         wave_d = 1'b0;
         carrier_d = 1'b0;
      end else if (tick) begin
         cnt_d = cnt_q + 8'h01;
         case (mode)
            TMH_MD_INTERVAL: begin
               if (match0) begin
                  cnt_d = 8'h00;
                  irq_d = 1'b1;
                  wave_d = !wave_q;
               end
            end
            TMH_MD_PWM: begin
               if (!phase_q && match0) begin
                  cnt_d = 8'h00;
                  irq_d = 1'b1;
                  wave_d = 1'b1;
                  phase_d = 1'b1;
               end else if (phase_q && match1) begin
                  wave_d = 1'b0;
                  phase_d = 1'b0;
               end
            end
            TMH_MD_CARRIER: begin
               if (!phase_q && match0) begin
                  cnt_d = 8'h00;
                  carrier_d = 1'b1;
                  phase_d = 1'b1;
               end else if (phase_q && match1) begin
                  cnt_d = 8'h00;
                  carrier_d = 1'b0;
                  phase_d = 1'b0;
                  irq_d = 1'b1;
               end
            end
            default: cnt_d = cnt_q; // prohibited code: counter holds
         endcase
      end
      // carrier enable takes effect only at a companion edge; drop is at once
      nrz_d = nrz_q;
      if (!nrzb) begin
         nrz_d = 1'b0;
      end else if (comp_rise) begin
         nrz_d = 1'b1;
      end
      if (mode == TMH_MD_CARRIER) begin
         level = nrz_q && (rmc ? carrier_q : 1'b1);
      end else begin
         level = wave_q;
      end
      tout_d = (en && toen) ? (level ^ tolev) : tolev;
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         cnt_q <= 8'h00;
         phase_q <= 1'b0;
         wave_q <= 1'b0;
         carrier_q <= 1'b0;
         nrz_q <= 1'b0;
         COMPARE_IRQ_OUT <= 1'b0;
         TIMER_OUT <= 1'b0;
         MODE_OUT <= 2'h0;
      end else begin
         cnt_q <= cnt_d;
         phase_q <= phase_d;
         wave_q <= wave_d;
         carrier_q <= carrier_d;
         nrz_q <= nrz_d;
         COMPARE_IRQ_OUT <= irq_d;
         TIMER_OUT <= tout_d;
         MODE_OUT <= mode_q[`TMH_MODE_MD_HI:`TMH_MODE_MD_LO];
      end
   end

   // ----------------------------------------------------------------------
   // pin assignment and pad drive
   // ----------------------------------------------------------------------
   logic [1:0] psel;
   tmh_pin_s p30_d, p34_d, p00_d;

   assign psel = pin_q[`TMH_PIN_SEL_HI:`TMH_PIN_SEL_LO];

   // timer output is ORed onto the latch, so the latch must be 0 to pass it
   always_comb begin
      p30_d.data = p3_lat_q[0] | ((psel == 2'h0) & tout_d);
      p30_d.oe = !p3_dir_q[0];
      p34_d.data = p3_lat_q[4] | ((psel == 2'h1) & tout_d);
      p34_d.oe = !p3_dir_q[4];
      p00_d.data = p0_lat_q[0] | ((psel == 2'h2) & tout_d);
      p00_d.oe = !p0_dir_q[0];
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         P3B0_PIN_OUT <= '0;
         P3B4_PIN_OUT <= '0;
         P0B0_PIN_OUT <= '0;
      end else begin
         P3B0_PIN_OUT <= p30_d;
         P3B4_PIN_OUT <= p34_d;
         P0B0_PIN_OUT <= p00_d;
      end
   end

endmodule

// ==== inc/tmh_consts.svh ====
// tmh_consts.svh - offsets, field positions, reset values and divider
// exponents of the timer control block; definitions only.
`ifndef TMH_CONSTS_SVH
`define TMH_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets on the internal bus
// ----------------------------------------------------------------------
`define TMH_OFS_PIN_ASSIGN 16'hff39
`define TMH_OFS_MODE 16'hff6c
`define TMH_OFS_CARRIER 16'hff6d
`define TMH_OFS_P0_DIR 16'hff20
`define TMH_OFS_P3_DIR 16'hff23
`define TMH_OFS_P0_LATCH 16'hff80
`define TMH_OFS_P3_LATCH 16'hff83

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TMH_MODE_EN_BIT 7
`define TMH_MODE_CKS_HI 6
`define TMH_MODE_CKS_LO 4
`define TMH_MODE_MD_HI 3
`define TMH_MODE_MD_LO 2
`define TMH_MODE_TOLEV_BIT 1
`define TMH_MODE_TOEN_BIT 0
`define TMH_CAR_RMC_BIT 2
`define TMH_CAR_NRZB_BIT 1
`define TMH_CAR_NRZ_BIT 0
`define TMH_PIN_SEL_HI 1
`define TMH_PIN_SEL_LO 0

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define TMH_RST_ZERO 8'h00
`define TMH_RST_DIR 8'hff
`define TMH_CAR_WMASK 8'h06
`define TMH_PIN_WMASK 8'h03
`define TMH_P0_DIR_WMASK 8'h01

// ----------------------------------------------------------------------
// count clock divider exponents
// ----------------------------------------------------------------------
`define TMH_DIV_PRS_1 2
`define TMH_DIV_PRS_2 4
`define TMH_DIV_PRS_3 6
`define TMH_DIV_PRS_4 12
`define TMH_DIV_LSO_5 6
`define TMH_DIV_LSO_6 15

`endif

// ==== inc/tmh_pkg.sv ====
// tmh_pkg.sv - types shared by the timer control block and its bench.
// assumes tmh_consts.svh is on the include path.
package tmh_pkg;

   // operating modes, in field code order
   typedef enum logic [1:0] {
      TMH_MD_INTERVAL,
      TMH_MD_CARRIER,
      TMH_MD_PWM,
      TMH_MD_PROHIBITED
   } tmh_mode_e;

   // one internal bus access: byte write, bit set, bit clear or read
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic bit_set;
      logic bit_clr;
      logic [2:0] bit_sel;
      logic rd;
   } tmh_bus_s;

   // pad side of one pin
   typedef struct packed {
      logic data;
      logic oe;
   } tmh_pin_s;

endpackage

// ==== rtl/tmh_prescale.sv ====
// tmh_prescale.sv - count clock enable for the timer from the peripheral
// clock or the synchronised low-speed oscillator edges.
// assumes lso_tick_in is a one-cycle pulse on the core clock.
`timescale 1ns/1ns
`include "tmh_consts.svh"

module tmh_prescale #(
   parameter int PRS_W = 12,
   parameter int LSO_W = 15
) (
   input wire logic clk_in,         // core clock
   input wire logic rstn_in,        // async reset, active low
   input wire logic run_in,         // timer enabled
   input wire logic [2:0] cks_in,   // clock select code
   input wire logic lso_tick_in,    // low-speed oscillator rising edge
   output logic tick_out            // one-cycle count enable
);

   if (PRS_W < `TMH_DIV_PRS_4 || LSO_W < `TMH_DIV_LSO_6 || LSO_W < PRS_W) begin : g_bad
      $error("tmh_prescale: divider too narrow");
   end

   logic [PRS_W-1:0] prs_q, prs_d;
   logic [LSO_W-1:0] lso_q, lso_d;

   // true when the low n bits of v are all ones
   function automatic logic low_ones(input logic [LSO_W-1:0] v, input int n);
      logic [LSO_W-1:0] m;
      m = LSO_W'((64'd1 << n) - 64'd1);
      return &(v | ~m);
   endfunction

   // ----------------------------------------------------------------------
   // dividers
   // ----------------------------------------------------------------------
   // dividers restart at enable: up to one count clock of start error
   always_comb begin
      prs_d = run_in ? prs_q + PRS_W'(1) : '0;
      lso_d = lso_q;
      if (!run_in) begin
         lso_d = '0;
      end else if (lso_tick_in) begin
         lso_d = lso_q + LSO_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prs_q <= '0;
         lso_q <= '0;
      end else begin
         prs_q <= prs_d;
         lso_q <= lso_d;
      end
   end

   // ----------------------------------------------------------------------
   // clock select
   // ----------------------------------------------------------------------
   always_comb begin
      case (cks_in)
         3'h0: tick_out = 1'b1;
         3'h1: tick_out = low_ones(LSO_W'(prs_q), `TMH_DIV_PRS_1);
         3'h2: tick_out = low_ones(LSO_W'(prs_q), `TMH_DIV_PRS_2);
         3'h3: tick_out = low_ones(LSO_W'(prs_q), `TMH_DIV_PRS_3);
         3'h4: tick_out = low_ones(LSO_W'(prs_q), `TMH_DIV_PRS_4);
         3'h5: tick_out = lso_tick_in && low_ones(lso_q, `TMH_DIV_LSO_5);
         3'h6: tick_out = lso_tick_in && low_ones(lso_q, `TMH_DIV_LSO_6);
         default: tick_out = lso_tick_in;
      endcase
      tick_out = tick_out && run_in;
   end

endmodule

// ==== testbench/tmh_timer_ctrl_checker.sv ====
// tmh_timer_ctrl_checker.sv - concurrent checks on the timer control ports.
// assumes the core clock domain only; bound into tmh_timer_ctrl below.
`timescale 1ns/1ns
`include "tmh_consts.svh"

module tmh_timer_ctrl_checker
   import tmh_pkg::*;
(
   input wire logic CORE_CLK_IN,          // core clock
   input wire logic RSTN_IN,              // async reset, active low
   input wire tmh_bus_s BUS_IN,           // bus access
   input wire logic [7:0] RDATA_OUT,      // read data
   input wire logic COMPARE_IRQ_OUT,      // match interrupt
   input wire logic TIMER_OUT,            // timer output
   input wire logic [1:0] MODE_OUT,       // mode field copy
   input wire tmh_pin_s P3B0_PIN_OUT      // default pin
);
   // ---------------------------------------------------------------
   // shadow registers
   // ---------------------------------------------------------------
   logic [7:0] mode_q, mode_d, car_q, car_d, pin_q, pin_d;
   logic dir_clr;

   // port 3 direction write or bit clear on the bus this cycle
   assign dir_clr = BUS_IN.addr == `TMH_OFS_P3_DIR && (BUS_IN.wr || BUS_IN.bit_clr);

   function automatic logic [7:0] upd(input logic [7:0] r, input tmh_bus_s b,
                                      input logic [15:0] ofs, input logic [7:0] wm);
      logic [7:0] m;
      m = (8'h01 << b.bit_sel) & wm;
      upd = r;
      if (b.addr == ofs) begin
         if (b.wr) upd = b.wdata & wm;
         else if (b.bit_set) upd = r | m;
         else if (b.bit_clr) upd = r & ~m;
      end
   endfunction

   always_comb begin
      mode_d = upd(mode_q, BUS_IN, `TMH_OFS_MODE, 8'hff);
      car_d = upd(car_q, BUS_IN, `TMH_OFS_CARRIER, `TMH_CAR_WMASK);
      pin_d = upd(pin_q, BUS_IN, `TMH_OFS_PIN_ASSIGN, `TMH_PIN_WMASK);
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         mode_q <= 8'h00;
         car_q <= 8'h00;
         pin_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         car_q <= car_d;
         pin_q <= pin_d;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   AST_RD_MODE: assert property (BUS_IN.rd && BUS_IN.addr == `TMH_OFS_MODE |=> RDATA_OUT == $past(mode_q))
      else $error("mode register read mismatch");
   AST_RD_CAR: assert property (BUS_IN.rd && BUS_IN.addr == `TMH_OFS_CARRIER |=> RDATA_OUT[7:1] == $past(car_q[7:1]))
      else $error("carrier register read mismatch");
   AST_RD_PIN: assert property (BUS_IN.rd && BUS_IN.addr == `TMH_OFS_PIN_ASSIGN |=> RDATA_OUT == $past(pin_q))
      else $error("pin assign read mismatch");
   AST_MODE_OUT: assert property (MODE_OUT == $past(mode_q[3:2]))
      else $error("mode field copy mismatch");
   // stable mode lets either output timing pass
   AST_IDLE_LEVEL: assert property (!(mode_q[7] && mode_q[0]) && $stable(mode_q) |-> TIMER_OUT == mode_q[1])
      else $error("output not at idle level");
   AST_NO_IRQ_OFF: assert property (!mode_q[7] && !$past(mode_q[7]) && !$past(mode_q[7], 2) |-> !COMPARE_IRQ_OUT)
      else $error("interrupt while stopped");
   AST_FLAG_LOW: assert property (BUS_IN.rd && BUS_IN.addr == `TMH_OFS_CARRIER && !car_q[1] && !$past(car_q[1]) |=> !RDATA_OUT[0])
      else $error("status flag set while carrier disabled");
   AST_OE_CAUSE: assert property ($rose(P3B0_PIN_OUT.oe) |-> $past(dir_clr, 2))
      else $error("pin driven without direction write");

   COV_IRQ: cover property (COMPARE_IRQ_OUT);
   COV_FLAG: cover property (BUS_IN.rd && BUS_IN.addr == `TMH_OFS_CARRIER ##1 RDATA_OUT[0]);
   COV_OE: cover property ($rose(P3B0_PIN_OUT.oe));
endmodule

bind tmh_timer_ctrl tmh_timer_ctrl_checker u_chk (
   .CORE_CLK_IN(CORE_CLK_IN),
   .RSTN_IN(RSTN_IN),
   .BUS_IN(BUS_IN),
   .RDATA_OUT(RDATA_OUT),
   .COMPARE_IRQ_OUT(COMPARE_IRQ_OUT),
   .TIMER_OUT(TIMER_OUT),
   .MODE_OUT(MODE_OUT),
   .P3B0_PIN_OUT(P3B0_PIN_OUT)
);

// ==== testbench/tmh_timer_ctrl_bench.sv ====
// tmh_timer_ctrl_bench.sv - self-checking bench of the timer control block.
// assumes tmh_pkg and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "tmh_consts.svh"

module tmh_timer_ctrl_bench
   import tmh_pkg::*;
;
   localparam logic [15:0] MD = `TMH_OFS_MODE;
   localparam logic [15:0] CR = `TMH_OFS_CARRIER;
   localparam logic [15:0] PS = `TMH_OFS_PIN_ASSIGN;
   localparam logic [15:0] D3 = `TMH_OFS_P3_DIR;
   localparam logic [15:0] D0 = `TMH_OFS_P0_DIR;
   localparam logic [15:0] L3 = `TMH_OFS_P3_LATCH;
   logic clk, rstn, comp, lso, irq, tout;
   tmh_bus_s bus;
   logic [7:0] rdata;
   logic [1:0] mode;
   tmh_pin_s p30, p34, p00;
   int errors, compares, i;
   int cyc = 0;
   logic [7:0] md [8] = '{8'h81, 8'h91, 8'h89, 8'h85, 8'hf1, 8'ha1, 8'hb1, 8'hd1};
   int per [8] = '{3, 12, 3, 5, 24, 48, 192, 1536};

   tmh_timer_ctrl dut (
      .CORE_CLK_IN(clk),
      .RSTN_IN(rstn),
      .BUS_IN(bus),
      .CMP0_VAL_IN(8'h02),
      .CMP1_VAL_IN(8'h01),
      .COMPANION_IRQ_IN(comp),
      .LSO_CLK_IN(lso),
      .RDATA_OUT(rdata),
      .COMPARE_IRQ_OUT(irq),
      .TIMER_OUT(tout),
      .MODE_OUT(mode),
      .P3B0_PIN_OUT(p30),
      .P3B4_PIN_OUT(p34),
      .P0B0_PIN_OUT(p00)
   );

   // ---------------------------------------------------------------
   // clocks and hang guard
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // free-running slow oscillator, 8 core cycles a period, moved on falling edges
   initial begin
      lso = 1'b0;
      forever begin
         repeat (4) @(negedge clk);
         lso = ~lso;
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         close_out;
      end
   end

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // k is {wr, bit_set, bit_clr, rd}; request held one full cycle
   task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic [3:0] k,
                      input logic [2:0] s);
      @(negedge clk);
      bus = '0;
      bus.addr = a;
      bus.wdata = d;
      {bus.wr, bus.bit_set, bus.bit_clr, bus.rd} = k;
      bus.bit_sel = s;
      @(negedge clk);
      bus = '0;
   endtask

   task automatic wb(input logic [15:0] a, input logic [7:0] d);
      acc(a, d, 4'h8, 3'h0);
   endtask

   task automatic bs(input logic [15:0] a, input logic [2:0] s);
      acc(a, 8'h00, 4'h4, s);
   endtask

   task automatic bc(input logic [15:0] a, input logic [2:0] s);
      acc(a, 8'h00, 4'h2, s);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      acc(a, 8'h00, 4'h1, 3'h0);
      check(rdata, e);
   endtask

   task automatic cnt(input int n, input int e);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (irq === 1'b1) c++;
      end
      check(c[7:0], e[7:0]);
   endtask

   task automatic pulse;
      @(negedge clk);
      comp = 1'b1;
      @(negedge clk);
      comp = 1'b0;
   endtask

   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      bus = '0;
      comp = 1'b0;
      rstn = 1'b0;
      errors = 0;
      compares = 0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      rd(MD, 8'h00);
      rd(CR, 8'h00);
      rd(PS, 8'h00);
      rd(D3, 8'hff);
      rd(D0, 8'hff);
      rd(16'hff6e, 8'h00);
      wb(CR, 8'hff);
      rd(CR, 8'h06);
      bs(CR, 3'h0);
      bs(CR, 3'h7);
      rd(CR, 8'h06);
      wb(PS, 8'hff);
      rd(PS, 8'h03);
      bc(PS, 3'h1);
      rd(PS, 8'h01);
      bs(MD, 3'h6);
      bs(MD, 3'h1);
      rd(MD, 8'h42);
      bc(MD, 3'h6);
      rd(MD, 8'h02);
      wb(CR, 8'h00);
      wb(PS, 8'h00);
      for (i = 0; i < 3; i++) begin
         wb(MD, {4'h0, i[1:0], 2'b10});
         @(negedge clk);
         check({6'h0, mode}, {6'h0, i[1:0]});
      end
      // idle level reaches the default pin once it is an output
      wb(MD, 8'h02);
      bc(D3, 3'h0);
      rd(D3, 8'hfe);
      repeat (3) @(negedge clk);
      check({7'h0, tout}, 8'h01);
      check({6'h0, p30}, 8'h03);
      check({6'h0, p34}, 8'h00);
      wb(MD, 8'h00);
      repeat (3) @(negedge clk);
      check({6'h0, p30}, 8'h01);
      bs(L3, 3'h0);
      repeat (3) @(negedge clk);
      check({6'h0, p30}, 8'h03);
      bc(L3, 3'h0);
      wb(MD, 8'h02);
      bc(D3, 3'h4);
      wb(PS, 8'h01);
      repeat (3) @(negedge clk);
      check({6'h0, p34}, 8'h03);
      check({6'h0, p30}, 8'h01);
      bc(D0, 3'h0);
      wb(PS, 8'h02);
      repeat (3) @(negedge clk);
      check({6'h0, p00}, 8'h03);
      check({6'h0, p34}, 8'h01);
      wb(PS, 8'h00);
      // interval, PWM and carrier modes and clock codes 0, 1, 2, 3, 5 and 7 run from a stop, ten periods counted
      for (i = 0; i < 8; i++) begin
         wb(MD, 8'h00);
         wb(MD, md[i]);
         repeat (40) @(negedge clk);
         cnt(10 * per[i], 10);
      end
      // slowest core-clock divider: one period inside the window
      wb(MD, 8'h00);
      wb(MD, 8'hc1);
      cnt(16384, 1);
      wb(MD, 8'h00);
      wb(MD, 8'h81);
      repeat (10) @(negedge clk);
      wb(MD, 8'h81);
      cnt(30, 10);
      wb(MD, 8'h01);
      repeat (3) @(negedge clk);
      cnt(20, 0);
      check({7'h0, tout}, 8'h00);
      // carrier status flag, both remote modes
      pulse;
      rd(CR, 8'h00);
      wb(CR, 8'h02);
      rd(CR, 8'h02);
      pulse;
      rd(CR, 8'h03);
      wb(CR, 8'h00);
      rd(CR, 8'h00);
      wb(CR, 8'h06);
      pulse;
      rd(CR, 8'h07);
      wb(CR, 8'h04);
      rd(CR, 8'h04);
      // remote output in carrier mode, high-level variant
      wb(CR, 8'h02);
      wb(MD, 8'h85);
      repeat (3) @(negedge clk);
      check({7'h0, tout}, 8'h00);
      pulse;
      repeat (3) @(negedge clk);
      check({7'h0, tout}, 8'h01);
      wb(CR, 8'h00);
      repeat (3) @(negedge clk);
      check({7'h0, tout}, 8'h00);
      wb(MD, 8'h00);
      close_out;
   end
endmodule
